// ---- pkg/sff_params.svh ----
// Offsets, field positions and reset values of the frame format block.
// Included by the package and by the design file; definitions only.
`ifndef SFF_PARAMS_SVH
`define SFF_PARAMS_SVH

`define SFF_OFS_RX_DATA   8'h00
`define SFF_OFS_TX_DATA   8'h04
`define SFF_OFS_RX_CFG    8'h08
`define SFF_OFS_TX_CFG    8'h0C
`define SFF_OFS_STATUS    8'h10

`define SFF_F_DUAL        0
`define SFF_F_CNT1        1
`define SFF_F_SIZE1       8
`define SFF_F_CNT2        11
`define SFF_F_SIZE2       18
`define SFF_F_DELAY       21
`define SFF_F_ALIGN       23

`define SFF_ST_RX_READY   0
`define SFF_ST_RX_OVERRUN 1
`define SFF_ST_TX_UNDERRUN 2
`define SFF_ST_FIFO_FULL  3
`define SFF_ST_FIFO_EMPTY 4

`define SFF_CFG_RESET     32'h0000_0000
`define SFF_FIFO_DEPTH    32
`define SFF_RESP_OKAY     2'h0
`define SFF_RESP_SLVERR   2'h2

`endif

// ---- pkg/sff_pkg.sv ----
// Types and decode functions of the frame format block.
// Assumes sff_params.svh is reachable on the include path.
package sff_pkg;
`include "sff_params.svh"

   typedef enum logic [1:0] {SFF_IDLE = 2'b00, SFF_DELAY = 2'b01, SFF_BIT = 2'b10} sff_state_t;

   typedef struct packed {
      logic [1:0] align;
      logic [1:0] delay;
      logic [2:0] size2;
      logic [6:0] cnt2;
      logic [2:0] size1;
      logic [6:0] cnt1;
      logic       dual;
   } sff_cfg_t;

   typedef struct packed {
      logic       done;
      logic       ph;
      logic [6:0] elem;
   } sff_pos_t;

   function automatic sff_cfg_t sff_unpack(input logic [31:0] w);
      sff_cfg_t c;
      c.dual  = w[`SFF_F_DUAL];
      c.cnt1  = w[`SFF_F_CNT1 +: 7];
      c.size1 = w[`SFF_F_SIZE1 +: 3];
      c.cnt2  = w[`SFF_F_CNT2 +: 7];
      c.size2 = w[`SFF_F_SIZE2 +: 3];
      c.delay = w[`SFF_F_DELAY +: 2];
      c.align = w[`SFF_F_ALIGN +: 2];
      return c;
   endfunction : sff_unpack

   // Reserved codes fall back to 32 bits
   function automatic logic [5:0] sff_bits(input logic [2:0] code);
      case (code)
         3'h0:    return 6'd8;
         3'h1:    return 6'd12;
         3'h2:    return 6'd16;
         3'h3:    return 6'd20;
         3'h4:    return 6'd24;
         default: return 6'd32;
      endcase
   endfunction : sff_bits

   // Position after the current element; phase two only when dual
   function automatic sff_pos_t sff_next(input sff_cfg_t c, input logic ph,
                                         input logic [6:0] elem);
      sff_pos_t p;
      p = '{done: 1'b0, ph: ph, elem: 7'(elem + 7'h1)};
      if (elem == (ph ? c.cnt2 : c.cnt1))
      begin
         if (!ph && c.dual)
            p = '{done: 1'b0, ph: 1'b1, elem: 7'h0};
         else
            p = '{done: 1'b1, ph: 1'b0, elem: 7'h0};
      end
      return p;
   endfunction : sff_next

   function automatic logic [31:0] sff_justify(input logic [31:0] v, input logic [5:0] w,
                                               input logic [1:0] m);
      logic [31:0] mask;
      logic        msb;
      mask = (w == 6'd32) ? 32'hFFFF_FFFF : 32'((33'h1 << w) - 33'h1);
      msb  = v[5'(w[4:0] - 5'h1)];
      case (m)
         2'h1:    return (v & mask) | (msb ? ~mask : 32'h0);
         2'h2:    return v << (6'd32 - w);
         default: return v & mask;
      endcase
   endfunction : sff_justify

   function automatic logic sff_mapped(input logic [7:0] a);
      return a == `SFF_OFS_RX_DATA || a == `SFF_OFS_TX_DATA || a == `SFF_OFS_RX_CFG
          || a == `SFF_OFS_TX_CFG || a == `SFF_OFS_STATUS;
   endfunction : sff_mapped

endpackage : sff_pkg

// ---- design/sff_frame_format.sv ----
// Frame format and data alignment of a buffered synchronous serial port.
// Assumes an AXI4-Lite master and an external peer driving bit clocks and syncs.
//
// Implementation choices: the address map and the AXI4-Lite slave port.
`include "sff_params.svh"

module sff_fifo
   import sff_pkg::*;
#(
   parameter int W = 32,
   parameter int D = `SFF_FIFO_DEPTH
)(
   input  wire logic         i_sys_clk,
   input  wire logic         i_reset_n,
   input  wire logic         i_in_valid,
   output logic              o_in_ready,
   input  wire logic [W-1:0] i_in_data,
   output logic              o_out_valid,
   input  wire logic         i_out_ready,
   output logic [W-1:0]      o_out_data
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem [D];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0]   count;
   logic          push;
   logic          pop;

   assign o_in_ready  = count != (AW+1)'(D);
   assign o_out_valid = count != '0;
   assign o_out_data  = mem[rd_ptr];
   assign push        = i_in_valid && o_in_ready;
   assign pop         = o_out_valid && i_out_ready;

   always_ff @(posedge i_sys_clk)
   begin
      if (push)
         mem[wr_ptr] <= i_in_data;
   end

   always_ff @(posedge i_sys_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end
      else
      begin
         if (push)
            wr_ptr <= (wr_ptr == AW'(D - 1)) ? '0 : AW'(wr_ptr + 1'b1);
         if (pop)
            rd_ptr <= (rd_ptr == AW'(D - 1)) ? '0 : AW'(rd_ptr + 1'b1);
         count <= (AW+1)'(count + push - pop);
      end
   end
endmodule : sff_fifo

module sff_frame_format
   import sff_pkg::*;
#(
   parameter int FIFO_DEPTH = `SFF_FIFO_DEPTH
)(
   input  wire logic        i_sys_clk,
   input  wire logic        i_reset_n,
   input  wire logic        i_awvalid,
   output logic             o_awready,
   input  wire logic [7:0]  i_awaddr,
   input  wire logic        i_wvalid,
   output logic             o_wready,
   input  wire logic [31:0] i_wdata,
   input  wire logic [3:0]  i_wstrb,
   output logic             o_bvalid,
   input  wire logic        i_bready,
   output logic [1:0]       o_bresp,
   input  wire logic        i_arvalid,
   output logic             o_arready,
   input  wire logic [7:0]  i_araddr,
   output logic             o_rvalid,
   input  wire logic        i_rready,
   output logic [31:0]      o_rdata,
   output logic [1:0]       o_rresp,
   input  wire logic        i_rx_bit_clock,
   input  wire logic        i_rx_frame_sync,
   input  wire logic        i_rx_data_pin,
   input  wire logic        i_tx_bit_clock,
   input  wire logic        i_tx_frame_sync,
   output logic             o_serial_out_pin
);
   logic [4:0]  s1, s2, s3, filt, filt_q;
   logic        rx_fall, rx_fs, rx_d, tx_rise, tx_fs;
   logic [31:0] rx_cfg_w, tx_cfg_w, rx_data_reg;
   sff_cfg_t    rxc, txc;
   logic        rx_ready, rx_overrun, tx_underrun;

   // Three-stage sampling; a level counts once stages two and three agree
   always_ff @(posedge i_sys_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         s1     <= '0;
         s2     <= '0;
         s3     <= '0;
         filt   <= '0;
         filt_q <= '0;
      end
      else
      begin
         s1     <= {i_rx_bit_clock, i_rx_frame_sync, i_rx_data_pin, i_tx_bit_clock,
                    i_tx_frame_sync};
         s2     <= s1;
         s3     <= s2;
         filt   <= (s3 & ~(s2 ^ s3)) | (filt & (s2 ^ s3));
         filt_q <= filt;
      end
   end

   // Data and sync pass the same stages as the clock, so they stay aligned
   assign rx_fall = filt_q[4] && !filt[4];
   assign rx_fs   = filt[3];
   assign rx_d    = filt[2];
   assign tx_rise = !filt_q[1] && filt[1];
   assign tx_fs   = filt[0];
   assign rxc     = sff_unpack(rx_cfg_w);
   assign txc     = sff_unpack(tx_cfg_w);

   // Receive engine
   sff_state_t  rx_state;
   logic        rx_ph, rx_cap, rx_last, rx_start, rx_load;
   logic [6:0]  rx_elem;
   logic [4:0]  rx_bit, rx_bidx;
   logic [1:0]  rx_wait;
   logic [5:0]  rx_bits, rx_hold_bits;
   logic [31:0] rx_shift, rx_holding_buffer;
   sff_pos_t    rx_nxt;

   assign rx_bits  = sff_bits(rx_ph ? rxc.size2 : rxc.size1);
   assign rx_start = rx_fall && rx_state == SFF_IDLE && rx_fs;
   assign rx_cap   = rx_fall && ((rx_start && rxc.delay == 2'h0)
                     || rx_state == SFF_BIT || (rx_state == SFF_DELAY && rx_wait == 2'h0));
   assign rx_bidx  = (rx_state == SFF_BIT) ? rx_bit : 5'h0;
   assign rx_last  = {1'b0, rx_bidx} == 6'(rx_bits - 6'd1);
   assign rx_nxt   = sff_next(rxc, rx_ph, rx_elem);

   always_ff @(posedge i_sys_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         rx_state <= SFF_IDLE;
         rx_ph    <= 1'b0;
         rx_elem  <= 7'h0;
         rx_bit   <= 5'h0;
         rx_wait  <= 2'h0;
         rx_shift <= 32'h0;
      end
      else if (rx_cap)
      begin
         rx_shift <= {rx_shift[30:0], rx_d};
         if (rx_last)
         begin
            rx_bit   <= 5'h0;
            rx_ph    <= rx_nxt.ph;
            rx_elem  <= rx_nxt.elem;
            rx_state <= rx_nxt.done ? SFF_IDLE : SFF_BIT;
         end
         else
         begin
            rx_bit   <= 5'(rx_bidx + 5'h1);
            rx_state <= SFF_BIT;
         end
      end
      else if (rx_start)
      begin
         rx_state <= SFF_DELAY;
         // Reserved code three waits like two
         rx_wait  <= {1'b0, rxc.delay[1]};
      end
      else if (rx_fall && rx_state == SFF_DELAY)
         rx_wait <= 2'(rx_wait - 2'h1);
   end

   always_ff @(posedge i_sys_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         rx_load           <= 1'b0;
         rx_holding_buffer <= 32'h0;
         rx_hold_bits      <= 6'd8;
         rx_data_reg       <= 32'h0;
      end
      else
      begin
         rx_load <= rx_cap && rx_last;
         if (rx_cap && rx_last)
         begin
            rx_holding_buffer <= {rx_shift[30:0], rx_d};
            rx_hold_bits      <= rx_bits;
         end
         if (rx_load)
            rx_data_reg <= sff_justify(rx_holding_buffer, rx_hold_bits, rxc.align);
      end
   end

   // Transmit engine fed by the FIFO
   sff_state_t  tx_state;
   logic        tx_ph, tx_loaded, tx_last, tx_start, tx_bound, tx_idle_load;
   logic [6:0]  tx_elem;
   logic [4:0]  tx_bit;
   logic [1:0]  tx_wait;
   logic [5:0]  tx_bits, tx_next_bits;
   logic [31:0] tx_shift_reg, fifo_data, tx_push_data;
   logic        fifo_valid, fifo_pop, fifo_in_ready, tx_push;
   sff_pos_t    tx_nxt;

   assign tx_bits      = sff_bits(tx_ph ? txc.size2 : txc.size1);
   assign tx_nxt       = sff_next(txc, tx_ph, tx_elem);
   assign tx_next_bits = sff_bits(tx_nxt.ph ? txc.size2 : txc.size1);
   assign tx_start     = tx_rise && tx_state == SFF_IDLE && tx_fs;
   assign tx_last      = tx_state == SFF_BIT && {1'b0, tx_bit} == 6'(tx_bits - 6'd1);
   assign tx_bound     = tx_rise && tx_last && !tx_nxt.done;
   assign tx_idle_load = tx_state == SFF_IDLE && !tx_loaded && fifo_valid && !tx_start;
   assign fifo_pop     = fifo_valid && (tx_idle_load || tx_bound);

   sff_fifo #(.W(32), .D(FIFO_DEPTH)) u_fifo (
      .i_sys_clk   (i_sys_clk),
      .i_reset_n   (i_reset_n),
      .i_in_valid  (tx_push),
      .o_in_ready  (fifo_in_ready),
      .i_in_data   (tx_push_data),
      .o_out_valid (fifo_valid),
      .i_out_ready (fifo_pop),
      .o_out_data  (fifo_data)
   );

   // First bit sits on the pin before the sync, so zero delay needs no wait
   assign o_serial_out_pin = tx_shift_reg[31];

   always_ff @(posedge i_sys_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         tx_state     <= SFF_IDLE;
         tx_ph        <= 1'b0;
         tx_elem      <= 7'h0;
         tx_bit       <= 5'h0;
         tx_wait      <= 2'h0;
         tx_loaded    <= 1'b0;
         tx_shift_reg <= 32'h0;
      end
      else if (tx_rise && tx_state == SFF_BIT)
      begin
         if (tx_last)
         begin
            tx_bit  <= 5'h0;
            tx_ph   <= tx_nxt.ph;
            tx_elem <= tx_nxt.elem;
            if (tx_nxt.done)
            begin
               tx_state  <= SFF_IDLE;
               tx_loaded <= 1'b0;
            end
            else
               tx_shift_reg <= fifo_valid ? sff_justify(fifo_data, tx_next_bits, 2'h2)
                                          : 32'h0;
         end
         else
         begin
            tx_bit       <= 5'(tx_bit + 5'h1);
            tx_shift_reg <= {tx_shift_reg[30:0], 1'b0};
         end
      end
      else if (tx_start)
      begin
         tx_state <= (txc.delay == 2'h0) ? SFF_BIT : SFF_DELAY;
         tx_wait  <= {1'b0, txc.delay[1]};
      end
      else if (tx_rise && tx_state == SFF_DELAY)
      begin
         if (tx_wait == 2'h0)
            tx_state <= SFF_BIT;
         else
            tx_wait <= 2'(tx_wait - 2'h1);
      end
      else if (tx_idle_load)
      begin
         tx_shift_reg <= sff_justify(fifo_data, sff_bits(txc.size1), 2'h2);
         tx_loaded    <= 1'b1;
      end
   end

   // AXI4-Lite slave: one write and one read in flight
   logic        aw_full, w_full, wr_do, rd_do, next_aw_full, next_w_full, next_bvalid;
   logic        next_rvalid;
   logic [7:0]  aw_addr;
   logic [31:0] w_data;
   logic [3:0]  w_strb;

   assign wr_do        = aw_full && w_full && !o_bvalid
                         && (aw_addr != `SFF_OFS_TX_DATA || fifo_in_ready);
   assign tx_push      = wr_do && aw_addr == `SFF_OFS_TX_DATA;
   assign tx_push_data = w_data;
   assign rd_do        = o_arready && i_arvalid;
   assign next_aw_full = (o_awready && i_awvalid) || (aw_full && !wr_do);
   assign next_w_full  = (o_wready && i_wvalid) || (w_full && !wr_do);
   assign next_bvalid  = wr_do || (o_bvalid && !i_bready);
   assign next_rvalid  = rd_do || (o_rvalid && !i_rready);

   always_ff @(posedge i_sys_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         aw_full   <= 1'b0;
         w_full    <= 1'b0;
         aw_addr   <= 8'h0;
         w_data    <= 32'h0;
         w_strb    <= 4'h0;
         o_awready <= 1'b0;
         o_wready  <= 1'b0;
         o_bvalid  <= 1'b0;
         o_bresp   <= `SFF_RESP_OKAY;
         rx_cfg_w  <= `SFF_CFG_RESET;
         tx_cfg_w  <= `SFF_CFG_RESET;
      end
      else
      begin
         if (o_awready && i_awvalid)
            aw_addr <= i_awaddr;
         if (o_wready && i_wvalid)
         begin
            w_data <= i_wdata;
            w_strb <= i_wstrb;
         end
         aw_full   <= next_aw_full;
         w_full    <= next_w_full;
         o_awready <= !next_aw_full && !next_bvalid;
         o_wready  <= !next_w_full && !next_bvalid;
         o_bvalid  <= next_bvalid;
         if (wr_do)
         begin
            o_bresp <= sff_mapped(aw_addr) ? `SFF_RESP_OKAY : `SFF_RESP_SLVERR;
            for (int b = 0; b < 4; b++)
            begin
               if (w_strb[b] && aw_addr == `SFF_OFS_RX_CFG)
                  rx_cfg_w[8*b +: 8] <= w_data[8*b +: 8];
               if (w_strb[b] && aw_addr == `SFF_OFS_TX_CFG)
                  tx_cfg_w[8*b +: 8] <= w_data[8*b +: 8];
            end
         end
      end
   end

   // Read side; a fresh event beats a clearing read in the same cycle
   always_ff @(posedge i_sys_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         o_arready   <= 1'b0;
         o_rvalid    <= 1'b0;
         o_rdata     <= 32'h0;
         o_rresp     <= `SFF_RESP_OKAY;
         rx_ready    <= 1'b0;
         rx_overrun  <= 1'b0;
         tx_underrun <= 1'b0;
      end
      else
      begin
         o_arready <= !next_rvalid;
         o_rvalid  <= next_rvalid;
         if (rd_do)
         begin
            o_rresp <= sff_mapped(i_araddr) ? `SFF_RESP_OKAY : `SFF_RESP_SLVERR;
            case (i_araddr)
               `SFF_OFS_RX_DATA: o_rdata <= rx_data_reg;
               `SFF_OFS_RX_CFG:  o_rdata <= rx_cfg_w;
               `SFF_OFS_TX_CFG:  o_rdata <= tx_cfg_w;
               `SFF_OFS_STATUS:  o_rdata <= 32'({!fifo_valid, !fifo_in_ready, tx_underrun,
                                                 rx_overrun, rx_ready});
               default:          o_rdata <= 32'h0;
            endcase
         end
         if (rx_load)
            rx_ready <= 1'b1;
         else if (rd_do && i_araddr == `SFF_OFS_RX_DATA)
            rx_ready <= 1'b0;
         if (rx_load && rx_ready)
            rx_overrun <= 1'b1;
         else if (rd_do && i_araddr == `SFF_OFS_STATUS)
            rx_overrun <= 1'b0;
         if ((tx_bound && !fifo_valid) || (tx_start && !tx_loaded))
            tx_underrun <= 1'b1;
         else if (rd_do && i_araddr == `SFF_OFS_STATUS)
            tx_underrun <= 1'b0;
      end
   end

   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_reset_n);

   property p_rx_ph2_dual;
      rx_ph |-> rxc.dual;
   endproperty
   a_rx_ph2_dual: assert property (p_rx_ph2_dual) else $error("phase two without dual");

   property p_rx_elem_bound;
      rx_state == SFF_BIT |-> rx_elem <= (rx_ph ? rxc.cnt2 : rxc.cnt1);
   endproperty
   a_rx_elem_bound: assert property (p_rx_elem_bound) else $error("element past count");

   property p_tx_bit_bound;
      tx_state == SFF_BIT |-> {1'b0, tx_bit} < tx_bits;
   endproperty
   a_tx_bit_bound: assert property (p_tx_bit_bound) else $error("bit past size");

   property p_rx_contig;
      rx_cap && rx_last && !rx_nxt.done |=> rx_state == SFF_BIT && rx_bit == 5'h0;
   endproperty
   a_rx_contig: assert property (p_rx_contig) else $error("gap between elements");

   property p_rx_zero_dly;
      rx_start && rxc.delay == 2'h0 |=> rx_state == SFF_BIT && rx_shift[0] == $past(rx_d);
   endproperty
   a_rx_zero_dly: assert property (p_rx_zero_dly) else $error("zero delay missed");

   property p_rx_start_fs;
      rx_start |-> rx_fs ##1 rx_state != SFF_IDLE;
   endproperty
   a_rx_start_fs: assert property (p_rx_start_fs) else $error("bad frame start");

   property p_tx_dly2;
      tx_start && txc.delay == 2'h2 |=> tx_state == SFF_DELAY && tx_wait == 2'h1;
   endproperty
   a_tx_dly2: assert property (p_tx_dly2) else $error("delay two wrong");

   property p_tx_zero_dly;
      tx_start && txc.delay == 2'h0 |=> tx_state == SFF_BIT && tx_bit == 5'h0
                                        && o_serial_out_pin == $past(tx_shift_reg[31]);
   endproperty
   a_tx_zero_dly: assert property (p_tx_zero_dly) else $error("first bit not held");

   property p_sign_ext;
      rx_load && rxc.align == 2'h1 && rx_hold_bits == 6'd12 && rx_holding_buffer[11]
         |=> rx_data_reg[31:12] == 20'hFFFFF;
   endproperty
   a_sign_ext: assert property (p_sign_ext) else $error("sign extension wrong");

   property p_left_just;
      rx_load && rxc.align == 2'h2 |=> rx_data_reg[31] == $past(
         rx_holding_buffer[5'(rx_hold_bits[4:0] - 5'h1)]);
   endproperty
   a_left_just: assert property (p_left_just) else $error("left alignment wrong");

   c_dual_frame: cover property (rx_cap && rx_last && rx_ph && rx_nxt.done);
   c_tx_delay2: cover property (tx_start && txc.delay == 2'h2);
   c_sign_load: cover property (rx_load && rxc.align == 2'h1);
   c_fifo_full: cover property (!fifo_in_ready);
endmodule : sff_frame_format

// ---- bench/sff_peer.sv ----
// Serial peer model: receive frame source and transmit pin sampler.
// Assumes one frame per direction at a time and a 48 ns link period.
module sff_peer (
   output logic      o_rx_clk,
   output logic      o_rx_fs,
   output logic      o_rx_dat,
   output logic      o_tx_clk,
   output logic      o_tx_fs,
   input  wire logic i_pin
);
   timeunit 1ns;
   timeprecision 100ps;
   initial
      {o_rx_clk, o_rx_fs, o_rx_dat, o_tx_clk, o_tx_fs} = 5'h00;
   // Clocks stand still between frames; idle data shows the inverse bit
   task automatic rx_frame(input logic b[$], input int d);
      // Step off the system clock edge that called us
      #1;
      for (int k = 0; k < d + b.size(); k++)
      begin
         o_rx_fs = (k == 0);
         o_rx_dat = (k >= d) ? b[k-d] : ~o_rx_dat;
         #4 o_rx_clk = 1'b1;
         #24 o_rx_clk = 1'b0;
         #20;
      end
      o_rx_fs = 1'b0;
      o_rx_dat = ~o_rx_dat;
   endtask : rx_frame
   // Sampled just before the next rising edge, after the pin has settled
   task automatic tx_frame(input int n, input int d, output logic q[$]);
      #1;
      for (int k = 0; k < d + n; k++)
      begin
         o_tx_fs = (k == 0);
         #4 o_tx_clk = 1'b1;
         #24 o_tx_clk = 1'b0;
         #19;
         if (k >= d)
            q.push_back(i_pin);
         #1;
      end
      o_tx_fs = 1'b0;
   endtask : tx_frame
endmodule : sff_peer

// ---- bench/serial_frame_format_align_tb.sv ----
// Self-checking bench: AXI4-Lite register tasks and peer-driven link frames.
// Assumes sff_pkg and the peer model are compiled first.
`include "sff_params.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module serial_frame_format_align_tb
   import sff_pkg::*;
();
   timeunit 1ns;
   timeprecision 100ps;
   logic        clk = 1'b0, rst_n = 1'b0, awv = 1'b0, wv = 1'b0, bre = 1'b0;
   logic        arv = 1'b0, rre = 1'b0;
   logic [7:0]  awa = 8'h00, ara = 8'h00;
   logic [31:0] wd = 32'h0, seed = 32'h1, rdat;
   logic        awr, wrd, bv, arr, rv, pin, rxc, rxf, rxd, txc, txf;
   logic [1:0]  br, rr;
   int          err_count = 0, cmp_count = 0;
   always #2.5 clk = ~clk;
   sff_frame_format i_dut (
      .i_sys_clk(clk), .i_reset_n(rst_n), .i_awvalid(awv), .o_awready(awr), .i_awaddr(awa),
      .i_wvalid(wv), .o_wready(wrd), .i_wdata(wd), .i_wstrb(4'hF), .o_bvalid(bv),
      .i_bready(bre), .o_bresp(br), .i_arvalid(arv), .o_arready(arr), .i_araddr(ara),
      .o_rvalid(rv), .i_rready(rre), .o_rdata(rdat), .o_rresp(rr), .i_rx_bit_clock(rxc),
      .i_rx_frame_sync(rxf), .i_rx_data_pin(rxd), .i_tx_bit_clock(txc),
      .i_tx_frame_sync(txf), .o_serial_out_pin(pin));
   sff_peer i_peer (.o_rx_clk(rxc), .o_rx_fs(rxf), .o_rx_dat(rxd), .o_tx_clk(txc),
      .o_tx_fs(txf), .i_pin(pin));
   function automatic logic [31:0] rnd();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed;
   endfunction : rnd
   function automatic int wid(input logic [2:0] c);
      return (c > 3'h4) ? 32 : 8 + 4 * c;
   endfunction : wid
   function automatic logic [31:0] place(input logic [31:0] v, input int w,
                                         input logic [1:0] m);
      for (int i = w; i < 32; i++)
         v[i] = (m == 2'h1) ? v[w-1] : 1'b0;
      return (m == 2'h2) ? v << (32 - w) : v;
   endfunction : place
   task automatic stop_test();
      $display("TB: compares=%0d mismatches=%0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : stop_test
   task automatic reset();
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
   endtask : reset
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge clk);
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      bre <= 1'b1;
      do
      begin
         @(posedge clk);
         if (awr)
            awv <= 1'b0;
         if (wrd)
            wv <= 1'b0;
      end
      while (!bv);
      r = br;
      bre <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk);
      ara <= a;
      arv <= 1'b1;
      rre <= 1'b1;
      do
      begin
         @(posedge clk);
         if (arr)
            arv <= 1'b0;
      end
      while (!rv);
      d = rdat;
      r = rr;
      rre <= 1'b0;
   endtask : rd
   // Elements past nw are zero, as an underrun sends
   task automatic mk(input sff_cfg_t c, input int nw, output logic [31:0] v[$],
                     output int w[$], output logic b[$]);
      for (int i = 0; i <= c.cnt1 + (c.dual ? c.cnt2 + 1 : 0); i++)
      begin
         w.push_back(wid((i > c.cnt1) ? c.size2 : c.size1));
         v.push_back((i < nw) ? rnd() & 32'((33'h1 << w[i]) - 33'h1) : 32'h0);
         for (int j = w[i] - 1; j >= 0; j--)
            b.push_back(v[i][j]);
      end
   endtask : mk
   task automatic rx_run(input sff_cfg_t c);
      logic [31:0] v[$], d;
      int          w[$];
      logic        b[$];
      logic [1:0]  r;
      wr(`SFF_OFS_RX_CFG, 32'(c), r);
      mk(c, 999, v, w, b);
      fork
         i_peer.rx_frame(b, c.delay);
         foreach (v[i])
         begin
            do
               rd(`SFF_OFS_STATUS, d, r);
            while (!d[`SFF_ST_RX_READY]);
            rd(`SFF_OFS_RX_DATA, d, r);
            `CHK(d, place(v[i], w[i], c.align))
         end
      join
   endtask : rx_run
   task automatic tx_run(input sff_cfg_t c, input int nw);
      logic [31:0] v[$], d;
      int          w[$];
      logic        b[$], q[$];
      logic [1:0]  r;
      reset();
      wr(`SFF_OFS_TX_CFG, 32'(c), r);
      mk(c, nw, v, w, b);
      if (nw > v.size())
         nw = v.size();
      for (int i = 0; i < nw; i++)
         wr(`SFF_OFS_TX_DATA, v[i], r);
      rd(`SFF_OFS_STATUS, d, r);
      `CHK(d[`SFF_ST_FIFO_FULL], 1'(nw > `SFF_FIFO_DEPTH))
      i_peer.tx_frame(b.size(), c.delay, q);
      foreach (b[i])
         `CHK(q[i], b[i])
      rd(`SFF_OFS_STATUS, d, r);
      `CHK(d[4:2], {2'b10, 1'(nw < v.size())})
   endtask : tx_run
   initial
   begin
      sff_cfg_t    c;
      logic [31:0] d;
      logic [1:0]  r;
      logic [31:0] v[$];
      int          w[$];
      logic        b[$];
      reset();
      rd(`SFF_OFS_TX_CFG, d, r);
      `CHK(d, `SFF_CFG_RESET)
      rd(8'h14, d, r);
      `CHK({r, d}, {`SFF_RESP_SLVERR, 32'h0})
      wr(8'h1C, rnd(), r);
      `CHK(r, `SFF_RESP_SLVERR)
      $display("TB: register test done");
      for (int i = 0; i < 18; i++)
      begin
         c = sff_cfg_t'(25'(rnd()));
         {c.dual, c.cnt1, c.size1, c.delay, c.align} = {8'h00, 3'(i % 6), 2'(i % 3), 2'(i / 6)};
         rx_run(c);
      end
      c = '{2'h1, 2'h1, 3'h0, 7'd2, 3'h1, 7'd1, 1'b1};
      rx_run(c);
      c = '{2'h2, 2'h0, 3'h0, 7'd127, 3'h0, 7'd127, 1'b1};
      rx_run(c);
      // Unread elements: the second overwrites the first and flags overrun
      c = '0;
      c.cnt1 = 7'd1;
      wr(`SFF_OFS_RX_CFG, 32'(c), r);
      mk(c, 9, v, w, b);
      i_peer.rx_frame(b, 0);
      repeat (10) @(posedge clk);
      rd(`SFF_OFS_STATUS, d, r);
      `CHK(d[1:0], 2'b11)
      rd(`SFF_OFS_RX_DATA, d, r);
      `CHK(d, v[1])
      $display("TB: receive tests done");
      for (int i = 0; i < 3; i++)
      begin
         c = sff_cfg_t'(25'(rnd()));
         {c.dual, c.cnt1, c.size1, c.cnt2, c.size2, c.delay} =
            {1'b1, 7'(i), 3'(rnd() % 6), 7'h1, 3'(rnd() % 6), 2'(i)};
         tx_run(c, 99);
      end
      c = '0;
      c.cnt1 = 7'd32;
      tx_run(c, 33);
      c.cnt1 = 7'd2;
      c.delay = 2'h1;
      tx_run(c, 2);
      $display("TB: transmit tests done");
      stop_test();
   end
   initial
   begin
      #400us;
      err_count++;
      stop_test();
   end
endmodule : serial_frame_format_align_tb
